/* sul_dev.sv */
`timescale 1ns/100ps
// Device end: decodes unlock, takes one sector, compares, updates lock
module sul_dev
   import sul_pkg::*;
(
   input  wire logic        CLK,
   input  wire logic        RST,
   input  wire logic        CE,
   sul_if.dev               LNK,
   input  wire logic        COMRESET,
   input  wire logic        SSP_ENABLE,
   input  wire logic        SEC_ENABLED,
   input  wire logic        LEVEL,
   input  wire logic        PW_WE,
   input  wire logic        PW_KIND,
   input  wire logic [3:0]  PW_IDX,
   input  wire logic [15:0] PW_WORD,
   output logic             LOCKED,
   output logic             PROTECT_REJECT,
   output logic [2:0]       ATTEMPTS
);
   import sul_pkg::*;
   typedef enum {S_IDLE, S_DATA, S_EVAL} sul_state_t;

   sul_state_t  st_reg, st_next;        // Command sequencer
   logic [7:0]  cnt_reg, cnt_next;      // Word index in sector
   logic [2:0]  att_reg, att_next;      // Attempts left
   logic        lock_reg, lock_next;    // Lock state
   logic        kind_reg, kind_next;    // Selected password kind
   logic        drq_reg, drq_next;      // Data request
   logic        done_reg, done_next;    // Completion pulse
   logic        abt_reg, abt_next;      // Abort flag
   logic        early_reg, early_next;  // Abort before data
   logic        locked_next;            // Next lock output
   logic        rej_next;               // Next protect-reject output
   logic        is_unlock;              // Unlock code on the link
   logic        last_word;              // Final word of the sector
   logic [15:0] user_pw   [PW_WORDS];   // Stored user password
   logic [15:0] master_pw [PW_WORDS];   // Stored master password
   logic [15:0] ref_pw    [PW_WORDS];   // Password chosen for compare
   logic        match;                  // Comparator result
   logic        in_pw;                  // Current word is password
   logic [3:0]  pw_idx;                 // Password word index

   // Stored passwords change only through the load port, never through
   // the unlock path, so a good unlock leaves them as they were
   // Storage has no reset; it stands for non-volatile memory
   always_ff @(posedge CLK) begin
      if (CE && PW_WE) begin
         if (PW_KIND == KIND_MASTER) begin
            // Master slot
            master_pw[PW_IDX] <= PW_WORD;
         end else begin
            // User slot
            user_pw[PW_IDX] <= PW_WORD;
         end
      end
   end

   // Password selection by kind
   genvar g;
   generate
      for (g = 0; g < PW_WORDS; g++) begin : g_ref
         assign ref_pw[g] = (kind_reg == KIND_MASTER) ? master_pw[g]
                                                      : user_pw[g];
      end
   endgenerate

   assign in_pw  = (cnt_reg >= 8'(PW_FIRST_WORD)) &&
                   (cnt_reg <= 8'(PW_LAST_WORD));
   assign pw_idx = 4'(cnt_reg - 8'(PW_FIRST_WORD));
   // Shared decodes of the command code and the word index
   assign is_unlock = (LNK.cmd == CMD_UNLOCK);
   assign last_word = (cnt_reg == 8'(SECTOR_WORDS - 1));

   // Running comparison over the sixteen password words
   sul_cmp u_sul_cmp (
      .CLK   (CLK),
      .RST   (RST),
      .CE    (CE),
      .START (st_reg == S_IDLE),
      .STEP  ((st_reg == S_DATA) && LNK.wvalid && in_pw),
      .IDX   (pw_idx),
      .WORD  (LNK.wdata),
      .REF   (ref_pw),
      .MATCH (match)
   );

   // Sequencer next state; one command at a time, one sector per command
   always_comb begin
      // Done is a pulse; the result flags hold until the next command
      st_next    = st_reg;
      cnt_next   = cnt_reg;
      att_next   = att_reg;
      lock_next  = lock_reg;
      kind_next  = kind_reg;
      drq_next   = drq_reg;
      done_next  = 1'b0;
      abt_next   = abt_reg;
      early_next = early_reg;
      case (st_reg)
         // Waiting for a command
         S_IDLE: begin
            if (LNK.cmd_valid && is_unlock) begin
               if (att_reg == 3'h0) begin
                  // Exhausted: refuse before any data
                  done_next  = 1'b1;
                  abt_next   = 1'b1;
                  early_next = 1'b1;
               end else begin
                  // Accepted: ask for the one sector
                  st_next    = S_DATA;
                  cnt_next   = 8'h00;
                  drq_next   = 1'b1;
                  abt_next   = 1'b0;
                  early_next = 1'b0;
               end
            end else if (LNK.cmd_valid) begin
               // Other commands are not ours; refuse early
               done_next  = 1'b1;
               abt_next   = 1'b1;
               early_next = 1'b1;
            end
         end
         // Taking the sector, one word per strobe
         S_DATA: begin
            if (LNK.wvalid) begin
               if (cnt_reg == 8'h00) begin
                  // Only the kind bit of the control word counts
                  kind_next = LNK.wdata[KIND_BIT];
               end
               // Word index counts every word of the sector
               cnt_next = cnt_reg + 8'h01;
               if (last_word) begin
                  // Sector complete; stop asking
                  drq_next = 1'b0;
                  st_next  = S_EVAL;
               end
            end
         end
         // Comparator has settled on the last password word
         S_EVAL: begin
            st_next   = S_IDLE;
            done_next = 1'b1;
            if (kind_reg == KIND_MASTER && LEVEL == LEVEL_MAXIMUM) begin
               // Not a mismatch, so no attempt is spent
               abt_next = 1'b1;
            end else if (match) begin
               // Good password: unlock
               lock_next = 1'b0;
               abt_next  = 1'b0;
            end else begin
               // Mismatch: abort after data, spend one attempt
               abt_next = 1'b1;
               att_next = att_reg - 3'h1;
            end
         end
         // Unused encodings fall back to idle
         default: st_next = S_IDLE;
      endcase
      // Link reset without preservation drops the command and loads the lock state with SEC_ENABLED
      if (COMRESET && !SSP_ENABLE) begin
         lock_next = SEC_ENABLED;
         st_next   = S_IDLE;
         drq_next  = 1'b0;
      end
      // Lock output is live only with the lock function on
      locked_next = lock_next & SEC_ENABLED;
      // Exhausted counter shuts out protected commands until power-on
      rej_next    = (att_next == 3'h0);
   end

   // Power-on relocks and reloads attempts
   always_ff @(posedge CLK) begin
      if (RST) begin
         st_reg    <= S_IDLE;
         cnt_reg   <= 8'h00;
         att_reg   <= ATTEMPTS_INIT;
         lock_reg  <= 1'b1;
         kind_reg  <= KIND_USER;
         drq_reg   <= 1'b0;
         done_reg  <= 1'b0;
         abt_reg   <= 1'b0;
         early_reg <= 1'b0;
         LOCKED    <= 1'b1;
         PROTECT_REJECT <= 1'b0;
      end else if (CE) begin
         st_reg    <= st_next;
         cnt_reg   <= cnt_next;
         att_reg   <= att_next;
         lock_reg  <= lock_next;
         kind_reg  <= kind_next;
         drq_reg   <= drq_next;
         done_reg  <= done_next;
         abt_reg   <= abt_next;
         early_reg <= early_next;
         LOCKED    <= locked_next;
         PROTECT_REJECT <= rej_next;
      end
   end
   // Outputs straight from their flip-flops
   assign ATTEMPTS  = att_reg;
   assign LNK.drq   = drq_reg;
   assign LNK.done  = done_reg;
   assign LNK.abort = abt_reg;
   assign LNK.early = early_reg;
endmodule : sul_dev

/* sul_pkg.sv */
// Contract
// - Command code F2h starts an unlock
// - Device requests one sector; password in words 1-16
// - Word 0 bit 0 picks user or master
// - Master at high level compares master password
// - Master at maximum level is rejected
// - User kind always compares user password
// - Match leaves locked state, enters unlocked
// - Unlock never alters stored passwords
// - Power-on or non-preserving COMRESET relocks; code relocks on COMRESET only with SEC_ENABLED high
// - Mismatch aborts and decrements attempt counter
// - Counter starts at 5; zero rejects protected commands
// - Abort after data only for mismatch; code also aborts after data for master kind at maximum level
// - Comparison covers all 32 password bytes
// - Security level: high zero, maximum one
package sul_pkg;
   localparam logic [7:0]  CMD_UNLOCK     = 8'hF2; // Unlock command code
   localparam int          SECTOR_WORDS   = 256;   // Words in one sector
   localparam int          PW_FIRST_WORD  = 1;     // First password word
   localparam int          PW_LAST_WORD   = 16;    // Last password word
   localparam int          PW_WORDS       = 16;    // Password length, words
   localparam int          KIND_BIT       = 0;     // Identifier bit position
   localparam logic        KIND_USER      = 1'b0;  // Identifier for user
   localparam logic        KIND_MASTER    = 1'b1;  // Identifier for master
   localparam logic        LEVEL_HIGH     = 1'b0;  // Security level high
   localparam logic        LEVEL_MAXIMUM  = 1'b1;  // Security level maximum
   localparam logic [2:0]  ATTEMPTS_INIT  = 3'h5;  // Attempts after power-on
   localparam logic [15:0] PW_RESET_WORD  = 16'h0000; // Unused; storage has no reset
   // Host-side register offsets
   localparam logic [3:0]  REG_CTRL       = 4'h0;  // Command code control
   localparam logic [3:0]  REG_PWDATA     = 4'h1;  // Password word fifo-less
   localparam logic [3:0]  REG_STATUS     = 4'h2;  // Result and busy
   localparam logic [3:0]  REG_IRQ_STAT   = 4'h3;  // Sticky events
   localparam logic [3:0]  REG_IRQ_CLR    = 4'h4;  // Write-one clear
   localparam logic [3:0]  REG_IRQ_EN     = 4'h5;  // Event enables
   localparam int          EV_DONE        = 0;     // Success event bit
   localparam int          EV_ABORT       = 1;     // Abort event bit
   localparam int          EV_WIDTH       = 2;     // Number of events
endpackage : sul_pkg

/* sul_if.sv */
`timescale 1ns/100ps
// Command link between host controller and device
interface sul_if;
   logic [7:0]  cmd;        // Command code
   logic        cmd_valid;  // One-cycle command strobe
   logic        drq;        // Device requests data, level
   logic [15:0] wdata;      // Data word from host
   logic        wvalid;     // One-cycle data word strobe
   logic        done;       // One-cycle completion pulse
   logic        abort;      // Abort flag with done
   logic        early;      // Abort came before data
   modport dev  (input cmd, cmd_valid, wdata, wvalid,
                 output drq, done, abort, early);
   modport host (output cmd, cmd_valid, wdata, wvalid,
                 input drq, done, abort, early);
endinterface : sul_if

/* sul_cmp.sv */
`timescale 1ns/100ps
// Running equality of received words against a stored password
module sul_cmp
   import sul_pkg::*;
(
   input  wire logic        CLK,
   input  wire logic        RST,
   input  wire logic        CE,
   input  wire logic        START,
   input  wire logic        STEP,
   input  wire logic [3:0]  IDX,
   input  wire logic [15:0] WORD,
   input  wire logic [15:0] REF [PW_WORDS],
   output logic             MATCH
);
   import sul_pkg::*;
   logic match_reg;   // Accumulated equality
   logic match_next;  // Next accumulated equality

   // Every word counts, so no byte is padding
   always_comb begin
      match_next = match_reg;
      if (START) begin
         match_next = 1'b1;
      end else if (STEP) begin
         match_next = match_reg & (WORD == REF[IDX]);
      end
   end

   // Registered result
   always_ff @(posedge CLK) begin
      if (RST) begin
         match_reg <= 1'b0;
      end else if (CE) begin
         match_reg <= match_next;
      end
   end
   assign MATCH = match_reg;
endmodule : sul_cmp

/* sul_host.sv */
`timescale 1ns/100ps
// Host end: software registers drive one unlock and collect the result
module sul_host
   import sul_pkg::*;
(
   input  wire logic        CLK,
   input  wire logic        RST,
   input  wire logic        CE,
   sul_if.host              LNK,
   input  wire logic [3:0]  ADDR,
   input  wire logic [15:0] WDATA,
   input  wire logic        WR,
   input  wire logic        RD,
   output logic [15:0]      RDATA,
   output logic             IRQ
);
   import sul_pkg::*;
   logic [7:0]  cmd_reg, cmd_next;        // Command code out
   logic        cv_reg, cv_next;          // Command strobe
   logic [15:0] wd_reg, wd_next;          // Data word out
   logic        wv_reg, wv_next;          // Data strobe
   logic        busy_reg, busy_next;      // Command in flight
   logic [1:0]  res_reg, res_next;        // Abort, early
   logic [EV_WIDTH-1:0] ist_reg, ist_next; // Sticky events
   logic [EV_WIDTH-1:0] ien_reg, ien_next; // Event enables
   logic [15:0] rd_reg, rd_next;          // Read data
   logic        irq_reg, irq_next;        // Interrupt
   logic [EV_WIDTH-1:0] ev;               // Events this cycle

   // Host registers, link strobes and events
   always_comb begin
      cmd_next = cmd_reg;
      cv_next  = 1'b0;
      wd_next  = wd_reg;
      wv_next  = 1'b0;
      busy_next = busy_reg;
      res_next = res_reg;
      ien_next = ien_reg;
      rd_next  = 16'h0000;
      ev = '0;
      if (LNK.done) begin
         busy_next = 1'b0;
         res_next  = {LNK.abort, LNK.early};
         ev[EV_DONE]  = ~LNK.abort;
         ev[EV_ABORT] = LNK.abort;
      end
      ist_next = ist_reg;
      if (WR && ADDR == REG_CTRL && !busy_reg) begin
         cmd_next  = WDATA[7:0];
         cv_next   = 1'b1;
         busy_next = 1'b1;
      end
      // Software paces words; words are taken only while requested
      if (WR && ADDR == REG_PWDATA && LNK.drq) begin
         wd_next = WDATA;
         wv_next = 1'b1;
      end
      if (WR && ADDR == REG_IRQ_EN) begin
         ien_next = WDATA[EV_WIDTH-1:0];
      end
      if (WR && ADDR == REG_IRQ_CLR) begin
         ist_next = ist_next & ~WDATA[EV_WIDTH-1:0];
      end
      ist_next = ist_next | ev; // Set wins over clear
      if (RD) begin
         case (ADDR)
            REG_CTRL:     rd_next = {8'h00, cmd_reg};
            REG_STATUS:   rd_next = {12'h000, LNK.drq, busy_reg, res_reg};
            REG_IRQ_STAT: rd_next = {14'h0, ist_reg};
            REG_IRQ_EN:   rd_next = {14'h0, ien_reg};
            default:      rd_next = 16'h0000;
         endcase
      end
      irq_next = |(ist_next & ien_next);
   end

   // State registers
   always_ff @(posedge CLK) begin
      if (RST) begin
         cmd_reg <= 8'h00;
         cv_reg  <= 1'b0;
         wd_reg  <= 16'h0000;
         wv_reg  <= 1'b0;
         busy_reg <= 1'b0;
         res_reg <= 2'h0;
         ist_reg <= '0;
         ien_reg <= '0;
         rd_reg  <= 16'h0000;
         irq_reg <= 1'b0;
      end else if (CE) begin
         cmd_reg <= cmd_next;
         cv_reg  <= cv_next;
         wd_reg  <= wd_next;
         wv_reg  <= wv_next;
         busy_reg <= busy_next;
         res_reg <= res_next;
         ist_reg <= ist_next;
         ien_reg <= ien_next;
         rd_reg  <= rd_next;
         irq_reg <= irq_next;
      end
   end
   assign LNK.cmd       = cmd_reg;
   assign LNK.cmd_valid = cv_reg;
   assign LNK.wdata     = wd_reg;
   assign LNK.wvalid    = wv_reg;
   assign RDATA = rd_reg;
   assign IRQ   = irq_reg;
endmodule : sul_host

/* sul_monitor.sv */
`timescale 1ns/100ps
// Watches the command link between the two ends
module sul_monitor
   import sul_pkg::*;
(
   input logic        CLK,
   input logic        RST,
   input logic [7:0]  cmd,
   input logic        cmd_valid,
   input logic        drq,
   input logic [15:0] wdata,
   input logic        wvalid,
   input logic        done,
   input logic        abort,
   input logic        early
);
   logic [8:0] n_words_reg;  // Words taken since the last command
   logic [8:0] n_words_next; // Next word count

   // Count words accepted while the device asks for data
   always_comb begin
      n_words_next = n_words_reg;
      if (cmd_valid) begin
         n_words_next = 9'h000;
      end else if (wvalid && drq) begin
         n_words_next = n_words_reg + 9'h001;
      end
   end

   // Register the count
   always_ff @(posedge CLK) begin
      if (RST) begin
         n_words_reg <= 9'h000;
      end else begin
         n_words_reg <= n_words_next;
      end
   end

   default clocking cb @(posedge CLK); endclocking
   default disable iff (RST);

   // Refusal shows before any data is asked for
   sequence s_refuse;
      done && abort && early && !drq;
   endsequence
   // Verdict after the sector is never an early abort
   sequence s_verdict;
      ##[1:3] (done && !early);
   endsequence

   property p_refuse;
      cmd_valid && cmd != CMD_UNLOCK |=> s_refuse;
   endproperty
   property p_accept;
      cmd_valid && cmd == CMD_UNLOCK |=> drq || (done && abort && early);
   endproperty
   property p_rose_drq;
      $rose(drq) |-> $past(cmd_valid) && $past(cmd) == CMD_UNLOCK;
   endproperty
   property p_count;
      $fell(drq) |-> n_words_reg == SECTOR_WORDS;
   endproperty
   property p_after_data;
      $fell(drq) |-> s_verdict;
   endproperty
   property p_words_in_drq;
      wvalid |-> drq;
   endproperty
   property p_pulse;
      done |=> !done;
   endproperty
   property p_hold;
      !cmd_valid ##1 !done |-> $stable(abort) && $stable(early);
   endproperty
   property p_early_abort;
      done && early |-> abort;
   endproperty
   property p_excl;
      done |-> !drq;
   endproperty

   a_refuse : assert property (p_refuse)
      else $error("non-unlock command not refused");
   a_accept : assert property (p_accept)
      else $error("unlock command not answered");
   a_rose_drq : assert property (p_rose_drq)
      else $error("data request without unlock command");
   a_count : assert property (p_count)
      else $error("data request not one sector long");
   a_after_data : assert property (p_after_data)
      else $error("no verdict after the sector");
   a_words_in_drq : assert property (p_words_in_drq)
      else $error("word sent without data request");
   a_pulse : assert property (p_pulse)
      else $error("done longer than one cycle");
   a_hold : assert property (p_hold)
      else $error("result flags changed between commands");
   a_early_abort : assert property (p_early_abort)
      else $error("early flag without abort");
   a_excl : assert property (p_excl)
      else $error("done while data still requested");
endmodule : sul_monitor

/* sul_bench.sv */
`timescale 1ns/100ps
module sul_bench;
   import sul_pkg::*;
   logic        CLK = 1'b0;      // Device clock
   logic        RST = 1'b1;      // Power-on reset
   logic [3:0]  addr = 4'h0;     // Host register address
   logic [15:0] wdata = 16'h0000;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   logic [15:0] rdata;
   logic        irq;
   logic        comreset = 1'b0;
   logic        ssp = 1'b0;      // Setting preservation
   logic        sec_en = 1'b1;   // Lock function on
   logic        ce = 1'b1;       // Clock enable of both ends
   logic        level = LEVEL_HIGH;
   logic        pw_we = 1'b0;
   logic        pw_kind = 1'b0;
   logic [3:0]  pw_idx = 4'h0;
   logic [15:0] pw_word = 16'h0000;
   logic        locked;
   logic        rej;
   logic [2:0]  att;
   logic [15:0] rv;              // Register read value
   logic        ab, ea, sent;    // Last command outcome
   int          errors = 0;
   int          n_checks = 0;

   always #5 CLK = ~CLK;

   sul_if lnk ();
   sul_dev u_sul_dev (.CLK(CLK), .RST(RST), .CE(ce), .LNK(lnk),
      .COMRESET(comreset), .SSP_ENABLE(ssp), .SEC_ENABLED(sec_en),
      .LEVEL(level), .PW_WE(pw_we), .PW_KIND(pw_kind), .PW_IDX(pw_idx),
      .PW_WORD(pw_word), .LOCKED(locked), .PROTECT_REJECT(rej),
      .ATTEMPTS(att));
   sul_host u_sul_host (.CLK(CLK), .RST(RST), .CE(ce), .LNK(lnk),
      .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
      .IRQ(irq));
   sul_monitor u_sul_monitor (.CLK(CLK), .RST(RST), .cmd(lnk.cmd),
      .cmd_valid(lnk.cmd_valid), .drq(lnk.drq), .wdata(lnk.wdata),
      .wvalid(lnk.wvalid), .done(lnk.done), .abort(lnk.abort),
      .early(lnk.early));

   // Compare and count
   task automatic chk(input string nm, input logic [15:0] e,
                      input logic [15:0] g);
      n_checks++;
      if (g !== e) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   // Verdict, reached from the main sequence or the watchdog
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : tally_and_finish

   task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
      @(posedge CLK);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge CLK);
      wr <= 1'b0;
   endtask : wr_reg

   // Read data stands only in the cycle after the strobe
   task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
      @(posedge CLK);
      addr <= a;
      rd <= 1'b1;
      @(posedge CLK);
      rd <= 1'b0;
      #1 d = rdata;
   endtask : rd_reg

   // Stored password words, distinct per kind
   function automatic logic [15:0] pw_of(input logic m, input int i);
      return (m ? 16'h5A00 : 16'hA500) + i[15:0];
   endfunction : pw_of

   // Bounded wait for a data request or a verdict
   task automatic wait_ev;
      for (int k = 0; k < 12; k++) begin
         @(posedge CLK);
         #1;
         if (lnk.done === 1'b1 || lnk.drq === 1'b1) break;
      end
   endtask : wait_ev

   // One command; the sector goes out only when asked for
   task automatic unlock(input logic [7:0] c, input logic [15:0] w0,
                         input logic m, input logic [15:0] flip);
      logic [15:0] w;
      sent = 1'b0;
      wr_reg(REG_CTRL, {8'h00, c});
      wait_ev();
      if (lnk.drq === 1'b1) begin
         sent = 1'b1;
         for (int i = 0; i < SECTOR_WORDS; i++) begin
            w = (i == 0) ? w0 : (i <= PW_LAST_WORD) ? pw_of(m, i)
                                                    : {i[7:0], 8'hC3};
            if (i == PW_LAST_WORD) w = w ^ flip;
            wr_reg(REG_PWDATA, w);
         end
         wait_ev();
      end
      ab = lnk.abort;
      ea = lnk.early;
      @(posedge CLK);
      #1;
   endtask : unlock

   task automatic res(input logic eab, input logic eea, input logic elk,
                      input logic [2:0] eat);
      chk("abort", {15'h0000, eab}, {15'h0000, ab});
      chk("early", {15'h0000, eea}, {15'h0000, ea});
      chk("locked", {15'h0000, elk}, {15'h0000, locked});
      chk("attempts", {13'h0000, eat}, {13'h0000, att});
   endtask : res

   // COMRESET pulse with the given preservation setting
   task automatic com_reset(input logic keep, input logic elk);
      @(posedge CLK);
      comreset <= 1'b1;
      ssp <= keep;
      @(posedge CLK);
      comreset <= 1'b0;
      @(posedge CLK);
      #1 chk("locked", {15'h0000, elk}, {15'h0000, locked});
   endtask : com_reset

   task automatic t_user;
      unlock(CMD_UNLOCK, 16'hFFFE, KIND_USER, 16'h0000);
      res(1'b0, 1'b0, 1'b0, 3'h5);
      rd_reg(REG_IRQ_STAT, rv);
      chk("irq_stat", 16'h0001, rv);
      chk("irq", 16'h0001, {15'h0000, irq});
      wr_reg(REG_IRQ_CLR, 16'h0003);
      rd_reg(REG_IRQ_STAT, rv);
      chk("irq_clr", 16'h0000, rv);
      chk("irq", 16'h0000, {15'h0000, irq});
      com_reset(1'b1, 1'b0);
      com_reset(1'b0, 1'b1);
      unlock(CMD_UNLOCK, 16'h0000, KIND_USER, 16'h0000);
      res(1'b0, 1'b0, 1'b0, 3'h5);
      com_reset(1'b0, 1'b1);
      $display("test user unlock finished");
   endtask : t_user

   task automatic t_master;
      @(posedge CLK);
      level <= LEVEL_MAXIMUM;
      unlock(CMD_UNLOCK, 16'h0001, KIND_MASTER, 16'h0000);
      res(1'b1, 1'b0, 1'b1, 3'h5);
      @(posedge CLK);
      level <= LEVEL_HIGH;
      unlock(CMD_UNLOCK, 16'h0001, KIND_MASTER, 16'h0000);
      res(1'b0, 1'b0, 1'b0, 3'h5);
      com_reset(1'b0, 1'b1);
      $display("test master unlock finished");
   endtask : t_master

   task automatic t_refuse;
      unlock(8'hF1, 16'h0000, KIND_USER, 16'h0000);
      res(1'b1, 1'b1, 1'b1, 3'h5);
      chk("sent", 16'h0000, {15'h0000, sent});
      rd_reg(REG_STATUS, rv);
      chk("status", 16'h0003, rv);
      $display("test refused command finished");
   endtask : t_refuse

   // Clock enable low freezes both ends; lock follows the lock function
   task automatic t_freeze;
      @(posedge CLK);
      ce <= 1'b0;
      wr_reg(REG_CTRL, {8'h00, CMD_UNLOCK});
      @(posedge CLK);
      #1 chk("frozen_drq", 16'h0000, {15'h0000, lnk.drq});
      @(posedge CLK);
      ce <= 1'b1;
      rd_reg(REG_STATUS, rv);
      chk("frozen_status", 16'h0003, rv);
      @(posedge CLK);
      sec_en <= 1'b0;
      com_reset(1'b0, 1'b0);
      @(posedge CLK);
      sec_en <= 1'b1;
      com_reset(1'b0, 1'b1);
      $display("test clock enable finished");
   endtask : t_freeze

   task automatic t_exhaust;
      for (int n = 4; n >= 0; n--) begin
         unlock(CMD_UNLOCK, 16'h0000, KIND_USER,
                n[0] ? 16'h8000 : 16'h0001);
         res(1'b1, 1'b0, 1'b1, n[2:0]);
      end
      chk("reject", 16'h0001, {15'h0000, rej});
      wr_reg(REG_IRQ_CLR, 16'h0003);
      wr_reg(REG_IRQ_EN, 16'h0000);
      unlock(CMD_UNLOCK, 16'h0000, KIND_USER, 16'h0000);
      res(1'b1, 1'b1, 1'b1, 3'h0);
      rd_reg(REG_IRQ_STAT, rv);
      chk("irq_stat", 16'h0002, rv);
      chk("irq", 16'h0000, {15'h0000, irq});
      @(posedge CLK);
      RST <= 1'b1;
      @(posedge CLK);
      RST <= 1'b0;
      @(posedge CLK);
      #1 chk("attempts", 16'h0005, {13'h0000, att});
      chk("reject", 16'h0000, {15'h0000, rej});
      chk("locked", 16'h0001, {15'h0000, locked});
      $display("test attempt counter finished");
   endtask : t_exhaust

   // Cuts a hang short
   initial begin
      #400000;
      errors++;
      tally_and_finish();
   end

   // Main sequence
   initial begin
      repeat (10) @(posedge CLK);
      RST <= 1'b0;
      @(posedge CLK);
      #1 chk("attempts", 16'h0005, {13'h0000, att});
      for (int i = 0; i < 2 * PW_WORDS; i++) begin
         @(posedge CLK);
         pw_we <= 1'b1;
         pw_kind <= i[4];
         pw_idx <= i[3:0];
         pw_word <= pw_of(i[4], i[3:0] + 1);
      end
      @(posedge CLK);
      pw_we <= 1'b0;
      wr_reg(REG_IRQ_EN, 16'h0003);
      t_user();
      t_master();
      t_refuse();
      t_freeze();
      t_exhaust();
      tally_and_finish();
   end
endmodule : sul_bench
